// ==== core/spd_pkg.sv ====
// Constants and types for the serial programmed divider logic
package spd_pkg;
  localparam int WORD_W          = 24;
  localparam int R_W             = 14;
  localparam int B_W             = 13;
  localparam int A_W             = 6;
  // Latch selector codes, bits 1:0 of the word
  localparam logic [1:0] SEL_REF_DIV  = 2'h0;
  localparam logic [1:0] SEL_FEEDBACK = 2'h1;
  localparam logic [1:0] SEL_CONTROL  = 2'h2;
  localparam logic [1:0] SEL_STARTUP  = 2'h3;
  // Reference divider latch fields
  localparam int REF_R_LSB        = 2;
  localparam int REF_ABP_LSB      = 16;
  localparam int REF_LDP_BIT      = 20;
  // Feedback divider latch fields
  localparam int FB_A_LSB         = 2;
  localparam int FB_B_LSB         = 8;
  localparam int FB_GAIN_BIT      = 21;
  // Operating control latch fields
  localparam int CTL_CNT_RST_BIT  = 2;
  localparam int CTL_PD_A_BIT     = 3;
  localparam int CTL_MUX_LSB      = 4;
  localparam int CTL_CP_HIZ_BIT   = 8;
  localparam int CTL_PD_B_BIT     = 21;
  localparam int CTL_PRESC_LSB    = 22;
  localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;
  localparam logic [B_W-1:0]    B_MIN       = 13'h0003;
  // Lock detect timing
  localparam int CLK_PERIOD_PS    = 10000;
  localparam int LOCK_ERR_NS      = 15;
  localparam int UNLOCK_ERR_NS    = 25;
  // Strictly below 15 ns: round down; above 25 ns: round up
  localparam int LOCK_ERR_CYC     = (LOCK_ERR_NS * 1000) / CLK_PERIOD_PS;
  localparam int UNLOCK_ERR_CYC   = (UNLOCK_ERR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [2:0] LOCK_RUN_COARSE = 3'h3;
  localparam logic [2:0] LOCK_RUN_FINE   = 3'h5;
  typedef enum logic [2:0] {
    MUX_HIZ, MUX_DLOCK, MUX_FB_DIV, MUX_HIGH,
    MUX_REF_DIV, MUX_ALOCK, MUX_SDATA, MUX_LOW
  } spd_mux_e;
endpackage : spd_pkg

// ==== core/spd_core.sv ====
// Serial programmed reference and feedback dividers with lock detect
// Functional notes
// - each serial clock rising edge shifts one data bit into 24-bit register.
// - words arrive most significant bit first; first bit ends as top bit.
// - load strobe rising edge copies the word into exactly one latch.
// - word bits 1 and 0 choose the destination latch.
// - 00 reference, 01 feedback, 10 and 11 both control latch.
// - 14-bit reference divider, ratios 1 to 16383, feeds phase detector.
// - feedback ratio equals prescaler modulus times main count plus swallow count.
// - main feedback counter is 13 bits, ratios 3 to 8191.
// - 6-bit swallow counter, 0 to 63, sets cycles at larger modulus.
// - prescaler selectable as 8/9, 16/17, 32/33 or 64/65.
// - precision bit clear: lock after three cycles under 15 ns.
// - precision bit set: lock after five cycles under 15 ns.
// - lock stays high until a cycle shows error above 25 ns.
// - three-bit output select field chooses the multiplexed output.
// - two-bit antibacklash width field; host avoids the minimum width.
// - analog lock output rests high with narrow low pulses when locked.
// - chip enable low powers down and floats the charge pump.
`timescale 1ns/1ps
module spd_core
  import spd_pkg::*;
#(
  parameter int ERR_CNT_W = 8
) (
  // System clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Serial programming link
  input  wire logic       link_clk_in,
  input  wire logic       serial_data_in,
  input  wire logic       load_strobe_in,
  // Pins
  input  wire logic       chip_enable_in,
  input  wire logic       ref_clk_pin_in,
  input  wire logic       rf_clk_pin_in,
  // Phase detector side
  output logic            pd_ref_pulse_out,
  output logic            pd_fb_pulse_out,
  output logic            cp_hiz_out,
  output logic            pump_gain_out,
  output logic [1:0]      antibacklash_width_out,
  output logic            lock_detect_out,
  // Multiplexed output pin
  output logic            multiplexed_output_pin_out,
  output logic            multiplexed_output_pin_oe_out
);

  // Link domain: shift register
  logic [WORD_W-1:0] shift_reg;

  always_ff @(posedge link_clk_in) begin
    shift_reg <= {shift_reg[WORD_W-2:0], serial_data_in};
  end

  // Pin synchronisers: strobe, enable, ref, rf
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  logic [3:0] pin_d_reg;
  logic [3:0] pin_rise;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      pin_d_reg  <= 4'h0;
    end else begin
      pin_s1_reg <= {rf_clk_pin_in, ref_clk_pin_in, chip_enable_in, load_strobe_in};
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_s2_reg;
    end
  end

  assign pin_rise = pin_s2_reg & ~pin_d_reg;

  logic load_evt;
  logic ce_s;
  logic ref_edge;
  logic rf_edge;
  assign load_evt = pin_rise[0];
  assign ce_s     = pin_s2_reg[1];
  assign ref_edge = pin_rise[2];
  assign rf_edge  = pin_rise[3];

  // Latches; the word is static while the strobe is high, so the late
  // synchronised edge still sees it settled in the link domain
  logic [WORD_W-1:0] reference_divider_latch_reg;
  logic [WORD_W-1:0] feedback_divider_latch_reg;
  logic [WORD_W-1:0] operating_control_latch_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      reference_divider_latch_reg <= LATCH_RESET;
      feedback_divider_latch_reg  <= LATCH_RESET;
      operating_control_latch_reg <= LATCH_RESET;
    end else if (load_evt) begin
      unique case (shift_reg[1:0])
        SEL_REF_DIV:  reference_divider_latch_reg <= shift_reg;
        SEL_FEEDBACK: feedback_divider_latch_reg  <= shift_reg;
        SEL_CONTROL,
        SEL_STARTUP:  operating_control_latch_reg <= shift_reg;
      endcase
    end
  end

  // Field decode
  logic [R_W-1:0] r_ratio;
  logic [B_W-1:0] b_ratio;
  logic [A_W-1:0] a_ratio;
  logic [6:0]     presc_p;
  logic           lock_precision_bit;
  logic           powered;
  logic           cnt_hold;
  spd_mux_e       mux_sel;

  function automatic logic [6:0] presc_modulus(input logic [1:0] code);
    unique case (code)
      2'h0:    presc_modulus = 7'h08;
      2'h1:    presc_modulus = 7'h10;
      2'h2:    presc_modulus = 7'h20;
      default: presc_modulus = 7'h40;
    endcase
  endfunction : presc_modulus

  always_comb begin
    r_ratio = reference_divider_latch_reg[REF_R_LSB +: R_W];
    if (r_ratio == '0) r_ratio = 14'h0001;
    b_ratio = feedback_divider_latch_reg[FB_B_LSB +: B_W];
    if (b_ratio < B_MIN) b_ratio = B_MIN;
    a_ratio = feedback_divider_latch_reg[FB_A_LSB +: A_W];
    presc_p = presc_modulus(operating_control_latch_reg[CTL_PRESC_LSB +: 2]);
    lock_precision_bit     = reference_divider_latch_reg[REF_LDP_BIT];
    mux_sel = spd_mux_e'(operating_control_latch_reg[CTL_MUX_LSB +: 3]);
    powered = ce_s && !operating_control_latch_reg[CTL_PD_A_BIT]
              && !operating_control_latch_reg[CTL_PD_B_BIT];
    cnt_hold = !powered || operating_control_latch_reg[CTL_CNT_RST_BIT];
  end

  // Reference divider
  logic [R_W-1:0] r_cnt_reg;
  logic           ref_pulse;
  assign ref_pulse = ref_edge && (r_cnt_reg == r_ratio - 14'h0001);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || cnt_hold) begin
      r_cnt_reg <= '0;
    end else if (ref_edge) begin
      r_cnt_reg <= ref_pulse ? '0 : r_cnt_reg + 14'h0001;
    end
  end

  // Feedback divider: prescaler, swallow and main counters
  logic [6:0]     p_cnt_reg;
  logic [A_W:0]   a_cnt_reg;
  logic [B_W-1:0] b_cnt_reg;
  logic [6:0]     modulus;
  logic           presc_wrap;
  logic           fb_pulse;

  assign modulus    = (a_cnt_reg < {1'b0, a_ratio}) ? presc_p + 7'h01 : presc_p;
  assign presc_wrap = rf_edge && (p_cnt_reg == modulus - 7'h01);
  assign fb_pulse   = presc_wrap && (b_cnt_reg == b_ratio - 13'h0001);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || cnt_hold) begin
      p_cnt_reg <= '0;
    end else if (rf_edge) begin
      p_cnt_reg <= presc_wrap ? '0 : p_cnt_reg + 7'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || cnt_hold) begin
      a_cnt_reg <= '0;
      b_cnt_reg <= '0;
    end else if (fb_pulse) begin
      a_cnt_reg <= '0;
      b_cnt_reg <= '0;
    end else if (presc_wrap) begin
      b_cnt_reg <= b_cnt_reg + 13'h0001;
      if (a_cnt_reg < {1'b0, a_ratio}) a_cnt_reg <= a_cnt_reg + 7'h01;
    end
  end

  // Phase error measurement between reference and feedback pulses
  logic                 pend_ref_reg;
  logic                 pend_fb_reg;
  logic [ERR_CNT_W-1:0] err_cnt_reg;
  logic                 meas_done;
  logic [ERR_CNT_W-1:0] meas_err;

  always_comb begin
    meas_done = 1'b0;
    meas_err  = err_cnt_reg;
    if (ref_pulse && fb_pulse) begin
      meas_done = 1'b1;
      meas_err  = '0;
    end else if ((pend_ref_reg && (fb_pulse || ref_pulse))
                 || (pend_fb_reg && (ref_pulse || fb_pulse))) begin
      meas_done = 1'b1;
      // A repeated edge on the same side means the partner was missed
      if ((pend_ref_reg && ref_pulse) || (pend_fb_reg && fb_pulse)) meas_err = '1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || cnt_hold) begin
      pend_ref_reg <= 1'b0;
      pend_fb_reg  <= 1'b0;
      err_cnt_reg  <= '0;
    end else if (ref_pulse && fb_pulse) begin
      pend_ref_reg <= 1'b0;
      pend_fb_reg  <= 1'b0;
      err_cnt_reg  <= '0;
    end else if (ref_pulse || fb_pulse) begin
      pend_ref_reg <= meas_done ? (meas_err == '1) && ref_pulse : ref_pulse;
      pend_fb_reg  <= meas_done ? (meas_err == '1) && fb_pulse : fb_pulse;
      err_cnt_reg  <= '0;
    end else if ((pend_ref_reg || pend_fb_reg) && err_cnt_reg != '1) begin
      err_cnt_reg <= err_cnt_reg + 1'b1;
    end
  end

  // Digital lock detect
  logic       good_cyc;
  logic       bad_cyc;
  logic [2:0] good_run_reg;
  logic       lock_reg;
  logic [2:0] run_need;

  assign good_cyc = meas_done && (meas_err < ERR_CNT_W'(LOCK_ERR_CYC));
  // Gap counter reads one less than the cycles between pulses
  assign bad_cyc  = meas_done && (meas_err >= ERR_CNT_W'(UNLOCK_ERR_CYC - 1));
  assign run_need = lock_precision_bit ? LOCK_RUN_FINE : LOCK_RUN_COARSE;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || cnt_hold) begin
      good_run_reg <= '0;
    end else if (meas_done) begin
      good_run_reg <= !good_cyc ? 3'h0 :
                      (good_run_reg == LOCK_RUN_FINE) ? good_run_reg : good_run_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || cnt_hold) begin
      lock_reg <= 1'b0;
    end else if (bad_cyc) begin
      lock_reg <= 1'b0;
    end else if (good_cyc && (good_run_reg + 3'h1 >= run_need)) begin
      lock_reg <= 1'b1;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pd_ref_pulse_out       <= 1'b0;
      pd_fb_pulse_out        <= 1'b0;
      cp_hiz_out             <= 1'b1;
      pump_gain_out          <= 1'b0;
      antibacklash_width_out <= 2'h0;
      lock_detect_out        <= 1'b0;
    end else begin
      pd_ref_pulse_out       <= ref_pulse;
      pd_fb_pulse_out        <= fb_pulse;
      cp_hiz_out             <= !powered || operating_control_latch_reg[CTL_CP_HIZ_BIT];
      pump_gain_out          <= feedback_divider_latch_reg[FB_GAIN_BIT];
      antibacklash_width_out <= reference_divider_latch_reg[REF_ABP_LSB +: 2];
      lock_detect_out        <= lock_reg;
    end
  end

  // Output multiplexer; analog lock pulls low while an error is open or lock is clear
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      multiplexed_output_pin_out    <= 1'b0;
      multiplexed_output_pin_oe_out <= 1'b0;
    end else begin
      multiplexed_output_pin_oe_out <= 1'b1;
      unique case (mux_sel)
        MUX_HIZ: begin
          multiplexed_output_pin_out    <= 1'b0;
          multiplexed_output_pin_oe_out <= 1'b0;
        end
        MUX_DLOCK:   multiplexed_output_pin_out <= lock_reg;
        MUX_FB_DIV:  multiplexed_output_pin_out <= fb_pulse;
        MUX_HIGH:    multiplexed_output_pin_out <= 1'b1;
        MUX_REF_DIV: multiplexed_output_pin_out <= ref_pulse;
        MUX_ALOCK: begin
          multiplexed_output_pin_out    <= 1'b0;
          multiplexed_output_pin_oe_out <= pend_ref_reg || pend_fb_reg || !lock_reg;
        end
        MUX_SDATA:   multiplexed_output_pin_out <= pin_s2_reg[0];
        MUX_LOW:     multiplexed_output_pin_out <= 1'b0;
      endcase
    end
  end

  // Checks
  sequence load_sel_s(logic [1:0] code);
    load_evt && shift_reg[1:0] == code;
  endsequence

  property latch_load_p(logic [1:0] code, logic [WORD_W-1:0] latch);
    @(posedge clk_in) disable iff (!rst_n_in)
      load_sel_s(code) |=> latch == $past(shift_reg);
  endproperty

  ref_latch_load_a: assert property (latch_load_p(SEL_REF_DIV, reference_divider_latch_reg))
    else $error("reference latch not loaded");
  fb_latch_load_a: assert property (latch_load_p(SEL_FEEDBACK, feedback_divider_latch_reg))
    else $error("feedback latch not loaded");
  ctl_only_one_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    load_sel_s(SEL_STARTUP) |=> $stable(reference_divider_latch_reg)
      && operating_control_latch_reg == $past(shift_reg))
    else $error("startup write touched wrong latch");
  ref_div_range_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ref_pulse && !cnt_hold |=> r_cnt_reg == '0)
    else $error("reference divider did not wrap");
  main_cnt_range_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    b_cnt_reg < b_ratio)
    else $error("main counter past ratio");
  swallow_mod_a: assert property (@(posedge clk_in) disable iff (!rst_n_in || cnt_hold)
    presc_wrap && !fb_pulse && modulus != presc_p |=> a_cnt_reg == $past(a_cnt_reg) + 7'h01)
    else $error("swallow count missed a larger modulus wrap");
  lock_coarse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in || cnt_hold)
    $rose(lock_reg) |-> $past(good_run_reg) >= 3'h2)
    else $error("lock set too early");
  lock_fine_a: assert property (@(posedge clk_in) disable iff (!rst_n_in || cnt_hold)
    $rose(lock_reg) && $past(lock_precision_bit) |-> $past(good_run_reg) >= 3'h4)
    else $error("fine lock set too early");
  lock_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in || cnt_hold)
    lock_reg && !bad_cyc |=> lock_reg)
    else $error("lock dropped without large error");
  mux_dlock_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mux_sel == MUX_DLOCK |=> multiplexed_output_pin_out == $past(lock_reg))
    else $error("mux does not show digital lock");
  alock_rest_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mux_sel == MUX_ALOCK && lock_reg && !pend_ref_reg && !pend_fb_reg
      |=> !multiplexed_output_pin_oe_out)
    else $error("analog lock not resting high");
  // Pump floats first, lock output follows one cycle behind
  sequence float_then_unlock_s;
    cp_hiz_out ##1 !lock_detect_out;
  endsequence

  powerdown_hiz_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !ce_s |=> float_then_unlock_s)
    else $error("pump not floated in power down");

endmodule : spd_core

// ==== dv/spd_host_model.sv ====
// Host side model of the three-wire programming link
`timescale 1ns/1ps
module spd_host_model (
  // Link pins
  output logic link_clk_out,
  output logic serial_data_out,
  output logic load_strobe_out
);
  initial begin
    link_clk_out    = 1'b0;
    serial_data_out = 1'b1;
    load_strobe_out = 1'b0;
  end

  // Clock stands low between words; idle data shows the inverse of the last bit
  task automatic send_word(input logic [23:0] word);
    #7;
    for (int i = 23; i >= 0; i--) begin
      serial_data_out = word[i];
      #32 link_clk_out = 1'b1;
      #32 link_clk_out = 1'b0;
    end
    serial_data_out = ~word[0];
    #100 load_strobe_out = 1'b1;
    // Strobe held well past the sync depth, link quiet meanwhile
    #80 load_strobe_out = 1'b0;
    #100;
  endtask : send_word
endmodule : spd_host_model

// ==== dv/spd_core_tb.sv ====
// Self-checking testbench for the serial programmed divider logic
`timescale 1ns/1ps
module spd_core_tb;
  import spd_pkg::*;
  logic       clk_in, rst_n_in, link_clk, sdata, strobe, chip_en, pin_clk;
  logic       pd_ref, pd_fb, cp_hiz, gain, lock, mux, mux_oe;
  logic [1:0] abw;
  int         fails, samples_checked, c, pulses;
  // Counters held, so pulse, lock and strobe sources all read low
  logic [2:0] codes [7] = '{3'h3, 3'h7, 3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
  logic [1:0] pins  [7] = '{2'h3, 2'h2, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2};

  spd_host_model u_host (
    .link_clk_out   (link_clk),
    .serial_data_out(sdata),
    .load_strobe_out(strobe)
  );
  spd_core u_dut (
    .clk_in                       (clk_in),
    .rst_n_in                     (rst_n_in),
    .link_clk_in                  (link_clk),
    .serial_data_in               (sdata),
    .load_strobe_in               (strobe),
    .chip_enable_in               (chip_en),
    .ref_clk_pin_in               (pin_clk),
    .rf_clk_pin_in                (pin_clk),
    .pd_ref_pulse_out             (pd_ref),
    .pd_fb_pulse_out              (pd_fb),
    .cp_hiz_out                   (cp_hiz),
    .pump_gain_out                (gain),
    .antibacklash_width_out       (abw),
    .lock_detect_out              (lock),
    .multiplexed_output_pin_out   (mux),
    .multiplexed_output_pin_oe_out(mux_oe)
  );

  initial clk_in = 1'b0;
  always #5 clk_in = ~clk_in;
  // One 25 MHz source feeds both pins so equal ratios line up in phase
  initial pin_clk = 1'b0;
  always #20 pin_clk = ~pin_clk;

  function automatic logic [23:0] fbw(input int b, input int a);
    fbw = (24'h1 << FB_GAIN_BIT) | (24'(b) << FB_B_LSB) | (24'(a) << FB_A_LSB) | 24'(SEL_FEEDBACK);
  endfunction : fbw

  function automatic logic [23:0] ctl(input logic [1:0] sel, input int p, input int m,
                                      input int hiz, input int rst);
    ctl = (24'(p) << CTL_PRESC_LSB) | (24'(hiz) << CTL_CP_HIZ_BIT) | (24'(m) << CTL_MUX_LSB)
        | (24'(rst) << CTL_CNT_RST_BIT) | 24'(sel);
  endfunction : ctl

  function automatic logic pick(input int which);
    case (which)
      0: pick = pd_ref;
      1: pick = pd_fb;
      default: pick = ~lock;
    endcase
  endfunction : pick

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic test_done();
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // Counts cycles until the chosen signal is high; running out is a failure
  task automatic wait_for(input int which, input int bound, output int cyc);
    cyc = 0;
    do begin
      @(posedge clk_in);
      #1;
      cyc++;
      if (cyc > bound) begin
        fails++;
        test_done();
      end
    end while (pick(which) !== 1'b1);
  endtask : wait_for

  // Counts feedback pulses until lock shows, giving up after eight
  task automatic lock_run(output int n);
    int cyc;
    n = 0;
    do begin
      wait_for(1, 300, cyc);
      n++;
      repeat (3) @(posedge clk_in);
      #1;
    end while (lock !== 1'b1 && n < 8);
  endtask : lock_run

  initial begin
    rst_n_in = 1'b0;
    chip_en  = 1'b1;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(posedge clk_in);
    // Width code 2 keeps clear of the minimum width
    u_host.send_word((24'h2 << REF_ABP_LSB) | (24'd56 << REF_R_LSB));
    check(abw, 2'h2);
    u_host.send_word(fbw(7, 0));
    check(gain, 1'b1);
    for (int i = 0; i < 7; i++) begin
      u_host.send_word(ctl(SEL_CONTROL, 0, codes[i], 0, 1));
      check({mux_oe, mux}, pins[i]);
    end
    u_host.send_word(ctl(SEL_STARTUP, 0, 3, 1, 1));
    check({cp_hiz, mux_oe, mux}, 3'h7);
    u_host.send_word(ctl(SEL_CONTROL, 0, 1, 0, 0));
    check(cp_hiz, 1'b0);
    lock_run(pulses);
    check(pulses, 3);
    check({mux_oe, mux}, 2'h3);
    // Locked with no open error: open drain released
    u_host.send_word(ctl(SEL_CONTROL, 0, 5, 0, 0));
    check({mux_oe, mux}, 2'h0);
    wait_for(0, 300, c);
    wait_for(0, 300, c);
    check(c, 224);
    // One extra RF edge per cycle walks the phase 4 cycles apart
    u_host.send_word(fbw(7, 1));
    wait_for(2, 1000, c);
    check(lock, 1'b0);
    check({mux_oe, mux}, 2'h2);
    // Precision bit set: realign both dividers, then five good cycles
    u_host.send_word((24'h1 << REF_LDP_BIT) | (24'h2 << REF_ABP_LSB)
                     | (24'd56 << REF_R_LSB));
    u_host.send_word(fbw(7, 0));
    u_host.send_word(ctl(SEL_CONTROL, 0, 1, 0, 1));
    u_host.send_word(ctl(SEL_CONTROL, 0, 1, 0, 0));
    lock_run(pulses);
    check(pulses, 5);
    for (int k = 0; k < 4; k++) begin
      u_host.send_word(fbw((8 << k) - 1, k));
      u_host.send_word(ctl(SEL_CONTROL, k, 2, 0, 0));
      wait_for(1, 17000, c);
      wait_for(1, 17000, c);
      check(c, 4 * ((8 << k) * ((8 << k) - 1) + k));
    end
    @(negedge clk_in);
    chip_en = 1'b0;
    repeat (6) @(posedge clk_in);
    #1;
    check(cp_hiz, 1'b1);
    check(lock, 1'b0);
    test_done();
  end
endmodule : spd_core_tb
